// *** logic/serial3w_ctrl.sv ***
// Purpose: two-channel 3-wire clocked serial block, register side and pin ownership
// Assumes: register strobes are one clock wide and synchronous to clock
// Notes: shift engines run on link_clock; events cross by toggles
`timescale 1ns/1ps
module serial3w_ctrl (
  // system clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link clock
  input wire logic link_clock,
  // register port
  input wire logic [serial3w_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [serial3w_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [serial3w_pkg::DATA_W-1:0] reg_rdata,
  // completion requests, one per channel
  output logic [1:0] transfer_done_irq_flag,
  // serial clock pins
  input wire logic [1:0] serial_clock_pin_in,
  output logic [1:0] serial_clock_pin_out,
  output logic [1:0] serial_clock_pin_oe,
  // serial data pins
  output logic [1:0] serial_out_pin,
  output logic [1:0] serial_out_pin_oe,
  input wire logic [1:0] serial_in_pin,
  // channel 1 slave select
  input wire logic slave_select_pin
);
  import serial3w_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] mode;
    logic [CLKSEL_W-1:0] clksel;
    logic [DATA_W-1:0] tx;
    logic [DATA_W-1:0] rx;
    logic busy;
    logic start_tgl;
    logic done_s1;
    logic done_s2;
    logic done_seen;
    logic irq;
    logic sck_oe;
    logic so_oe;
  } chan_state_t;

  typedef struct packed {
    chan_state_t [1:0] ch;
    logic [DATA_W-1:0] rdata;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t next_s;
  logic [1:0] done_tgl;
  logic [1:0][DATA_W-1:0] rx_byte;
  logic [1:0] chan_rst_n;

  // ----------------------------------------------------------------------------
  // shift engines, one per channel
  // ----------------------------------------------------------------------------
  for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_chan
    // flop output gated by rst_n only, so no glitch reaches the async reset
    assign chan_rst_n[i] = rst_n & s.ch[i].mode[MODE_EN_BIT];
    serial3w_engine u_engine (
      .link_clock(link_clock),
      .chan_rst_n(chan_rst_n[i]),
      .cfg_lsb_first(s.ch[i].mode[MODE_DIR_BIT]),
      .cfg_ckp(s.ch[i].clksel[CLKSEL_CKP_BIT]),
      .cfg_dap(s.ch[i].clksel[CLKSEL_DAP_BIT]),
      .cfg_cks(s.ch[i].clksel[CLKSEL_CKS_MSB:0]),
      .cfg_sse(s.ch[i].mode[MODE_SSE_BIT]),
      .tx_byte(s.ch[i].tx),
      .start_tgl(s.ch[i].start_tgl),
      .done_tgl(done_tgl[i]),
      .rx_byte(rx_byte[i]),
      .sck_in(serial_clock_pin_in[i]),
      .si_in(serial_in_pin[i]),
      .ssi_in(i == 1 ? slave_select_pin : 1'b0),
      .sck_out(serial_clock_pin_out[i]),
      .so_out(serial_out_pin[i])
    );
  end

  // ----------------------------------------------------------------------------
  // register side
  // ----------------------------------------------------------------------------
  always_comb begin
    logic en;
    logic start;
    next_s = s;
    en = 1'b0;
    start = 1'b0;
    next_s.rdata = BYTE_RESET;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      en = s.ch[i].mode[MODE_EN_BIT];
      start = 1'b0;
      next_s.ch[i].irq = 1'b0;
      next_s.ch[i].done_s1 = done_tgl[i];
      next_s.ch[i].done_s2 = s.ch[i].done_s1;
      // completion: capture data, clear busy, pulse the request
      if (s.ch[i].done_s2 != s.ch[i].done_seen) begin
        next_s.ch[i].done_seen = s.ch[i].done_s2;
        next_s.ch[i].busy = 1'b0;
        next_s.ch[i].irq = 1'b1;
        next_s.ch[i].rx = rx_byte[i]; // engine holds it until the next start
      end
      if (reg_write && reg_addr == MODE_ADDR[i]) begin
        next_s.ch[i].mode = reg_wdata & MODE_WMASK[i];
      end
      if (reg_write && reg_addr == CLKSEL_ADDR[i]) begin
        next_s.ch[i].clksel = reg_wdata[CLKSEL_W-1:0];
      end
      if (reg_write && reg_addr == TXBUF_ADDR[i] && !s.ch[i].busy) begin
        next_s.ch[i].tx = reg_wdata;
        start = 1'b1;
      end
      if (reg_read && reg_addr == SHIFT_ADDR[i]) begin
        start = 1'b1;
      end
      // busy never clears in the same cycle it is set; a start requested while busy is dropped
      if (start && en && !s.ch[i].busy) begin
        next_s.ch[i].busy = 1'b1;
        next_s.ch[i].start_tgl = ~s.ch[i].start_tgl;
      end
      if (!en) begin
        // stop mode: no transfer, crossing state back to its reset pairing
        next_s.ch[i].busy = 1'b0;
        next_s.ch[i].start_tgl = 1'b0;
        next_s.ch[i].done_s1 = 1'b0;
        next_s.ch[i].done_s2 = 1'b0;
        next_s.ch[i].done_seen = 1'b0;
        next_s.ch[i].rx = BYTE_RESET;
      end
      // pin ownership; unused pins stay with the port
      next_s.ch[i].sck_oe = next_s.ch[i].mode[MODE_EN_BIT] &&
                            next_s.ch[i].clksel[CLKSEL_CKS_MSB:0] != CKS_EXTERNAL;
      next_s.ch[i].so_oe = next_s.ch[i].mode[MODE_EN_BIT] & next_s.ch[i].mode[MODE_TRMD_BIT];
      if (reg_read && reg_addr == MODE_ADDR[i]) begin
        next_s.rdata = s.ch[i].mode;
        // busy drops a cycle after the enable clears; mask it so it never reads set then
        next_s.rdata[MODE_BUSY_BIT] = s.ch[i].busy & en;
      end
      if (reg_read && reg_addr == CLKSEL_ADDR[i]) begin
        next_s.rdata = {{(DATA_W-CLKSEL_W){1'b0}}, s.ch[i].clksel};
      end
      if (reg_read && reg_addr == TXBUF_ADDR[i]) begin
        next_s.rdata = s.ch[i].tx;
      end
      if (reg_read && reg_addr == SHIFT_ADDR[i]) begin
        next_s.rdata = s.ch[i].rx;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        s.ch[i].mode <= MODE_RESET;
        s.ch[i].clksel <= CLKSEL_RESET;
      end
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign reg_rdata = s.rdata;
  for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_out
    assign transfer_done_irq_flag[i] = s.ch[i].irq;
    assign serial_clock_pin_oe[i] = s.ch[i].sck_oe;
    assign serial_out_pin_oe[i] = s.ch[i].so_oe;
  end

endmodule

// *** logic/serial3w_engine.sv ***
// Purpose: link-side shift engine of one channel, clocked by the link clock
// Assumes: configuration inputs are static while a transfer runs
// Notes: chan_rst_n is asserted asynchronously and released in step with link_clock
`timescale 1ns/1ps
module serial3w_engine (
  // link clock and channel reset
  input wire logic link_clock,
  input wire logic chan_rst_n,
  // configuration from the register side
  input wire logic cfg_lsb_first,
  input wire logic cfg_ckp,
  input wire logic cfg_dap,
  input wire logic [2:0] cfg_cks,
  input wire logic cfg_sse,
  input wire logic [serial3w_pkg::DATA_W-1:0] tx_byte,
  // events across the crossing
  input wire logic start_tgl,
  output logic done_tgl,
  output logic [serial3w_pkg::DATA_W-1:0] rx_byte,
  // pins
  input wire logic sck_in,
  input wire logic si_in,
  input wire logic ssi_in,
  output logic sck_out,
  output logic so_out
);
  import serial3w_pkg::*;

  typedef struct packed {
    logic sck_s1;
    logic sck_s2;
    logic si_s1;
    logic si_s2;
    logic ssi_s1;
    logic ssi_s2;
    logic start_s1;
    logic start_s2;
    logic start_seen;
    logic sck_prev;
    logic active;
    logic sck_o;
    logic so_q;
    logic done;
    logic [DIV_W-1:0] div;
    logic [EDGE_CNT_W-1:0] edges;
    logic [BIT_CNT_W-1:0] bits;
    logic [DATA_W-1:0] sh;
  } engine_state_t;

  engine_state_t s;
  engine_state_t next_s;
  logic rst_s1;
  logic rst_s2;
  logic slave;
  logic idle;
  logic hold;
  logic lead;
  logic trail;
  logic smp;
  logic shf;

  // ----------------------------------------------------------------------------
  // reset release synchroniser
  // ----------------------------------------------------------------------------
  // clearing the enable resets at once; release waits for two link edges
  always_ff @(posedge link_clock or negedge chan_rst_n) begin
    if (!chan_rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sck_s1 = sck_in;
    next_s.sck_s2 = s.sck_s1;
    next_s.si_s1 = si_in;
    next_s.si_s2 = s.si_s1;
    next_s.ssi_s1 = ssi_in;
    next_s.ssi_s2 = s.ssi_s1;
    next_s.start_s1 = start_tgl;
    next_s.start_s2 = s.start_s1;
    // tracked always so a suspension never fakes an edge
    next_s.sck_prev = s.sck_s2;
    slave = (cfg_cks == CKS_EXTERNAL);
    idle = ~cfg_ckp;
    hold = cfg_sse & slave & s.ssi_s2;
    lead = 1'b0;
    trail = 1'b0;
    smp = 1'b0;
    shf = 1'b0;
    if (!s.active) begin
      next_s.sck_o = idle;
    end
    if (s.start_s2 != s.start_seen && !s.active && !hold) begin
      next_s.start_seen = s.start_s2;
      next_s.active = 1'b1;
      next_s.sh = tx_byte;
      next_s.so_q = cfg_lsb_first ? tx_byte[0] : tx_byte[DATA_W-1];
      next_s.div = '0;
      next_s.edges = '0;
      next_s.bits = '0;
    end else if (s.active && !hold) begin
      if (slave) begin
        lead = (s.sck_prev == idle) && (s.sck_s2 != idle);
        trail = (s.sck_prev != idle) && (s.sck_s2 == idle);
      end else if (s.div == (DIV_ONE << cfg_cks) - DIV_ONE) begin
        // master: half period of 2^cks link cycles
        next_s.div = '0;
        next_s.sck_o = ~s.sck_o;
        lead = (s.sck_o == idle);
        trail = (s.sck_o != idle);
        next_s.edges = s.edges + 1'b1;
      end else begin
        next_s.div = s.div + DIV_ONE;
      end
      // phase type picks which edge samples and which shifts
      smp = cfg_dap ? lead : trail;
      shf = cfg_dap ? trail : lead;
      if (smp) begin
        next_s.sh = cfg_lsb_first ? {s.si_s2, s.sh[DATA_W-1:1]} : {s.sh[DATA_W-2:0], s.si_s2};
        next_s.bits = s.bits + 1'b1;
      end
      if (shf) begin
        next_s.so_q = cfg_lsb_first ? s.sh[0] : s.sh[DATA_W-1];
      end
      // eight bits, then done; master also returns the clock to idle
      if ((slave && smp && s.bits == LAST_BIT) ||
          (!slave && (lead | trail) && s.edges == LAST_EDGE)) begin
        next_s.active = 1'b0;
        next_s.done = ~s.done;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge link_clock or negedge rst_s2) begin
    if (!rst_s2) begin
      s <= '0;
      s.sck_o <= 1'b1; // type 1 idles high
      // pin idles high, so the edge detector sees no false edge on release
      s.sck_s1 <= 1'b1;
      s.sck_s2 <= 1'b1;
      s.sck_prev <= 1'b1;
      s.sh <= BYTE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign done_tgl = s.done;
  assign rx_byte = s.sh;
  assign sck_out = s.sck_o;
  assign so_out = s.so_q;

endmodule

// *** logic/serial3w_pkg.sv ***
// Purpose: shared constants and types of the two-channel 3-wire serial block
// Assumes: 8-bit register port with a 16-bit address, two channels alike but for the slave-select enable
// Notes: channel index 0 and 1 select the per-channel entries of the address tables
package serial3w_pkg;

  // ----------------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------------
  localparam int NUM_CHANNELS = 2;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int CLKSEL_W = 5;
  localparam int DIV_W = 7;
  localparam int BIT_CNT_W = 4;
  localparam int EDGE_CNT_W = 5;

  // ----------------------------------------------------------------------------
  // register addresses, entry [i] belongs to channel i
  // ----------------------------------------------------------------------------
  localparam logic [1:0][ADDR_W-1:0] MODE_ADDR = {16'hff88, 16'hff80};
  localparam logic [1:0][ADDR_W-1:0] CLKSEL_ADDR = {16'hff89, 16'hff81};
  localparam logic [1:0][ADDR_W-1:0] TXBUF_ADDR = {16'hff8c, 16'hff84};
  localparam logic [1:0][ADDR_W-1:0] SHIFT_ADDR = {16'hff8d, 16'hff85};

  // ----------------------------------------------------------------------------
  // mode register layout
  // ----------------------------------------------------------------------------
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_TRMD_BIT = 6;
  localparam int MODE_SSE_BIT = 5;
  localparam int MODE_DIR_BIT = 4;
  localparam int MODE_BUSY_BIT = 0;
  localparam logic [DATA_W-1:0] MODE_RESET = 8'h00;
  // writable bits; the slave-select enable exists on channel 1 only
  localparam logic [1:0][DATA_W-1:0] MODE_WMASK = {8'hf0, 8'hd0};

  // ----------------------------------------------------------------------------
  // clock selection register layout
  // ----------------------------------------------------------------------------
  localparam int CLKSEL_CKP_BIT = 4;
  localparam int CLKSEL_DAP_BIT = 3;
  localparam int CLKSEL_CKS_MSB = 2;
  localparam logic [CLKSEL_W-1:0] CLKSEL_RESET = 5'h00;
  localparam logic [2:0] CKS_EXTERNAL = 3'h7;

  // ----------------------------------------------------------------------------
  // misc reset values and transfer figures
  // ----------------------------------------------------------------------------
  localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'h7;
  localparam logic [EDGE_CNT_W-1:0] LAST_EDGE = 5'h0f;
  localparam logic [DIV_W-1:0] DIV_ONE = 7'h01;

endpackage

// *** sim/clocked_serial_3wire_control_test.sv ***
// Purpose: register-level tests of the two-channel 3-wire serial block
// Assumes: channel 0 talks to a peer model, channel 1 is looped back
// Notes: reading the shift register starts a reception, so reads are ordered
`timescale 1ns/1ps
module clocked_serial_3wire_control_test;
  import serial3w_pkg::*;
  logic clock, rst_n, link_clock, reg_write, reg_read, load, ssel, si0;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, peer_tx, peer_rx;
  logic [1:0] irq, sck_out, sck_oe, so_out, so_oe;
  wire logic [1:0] sck_line;
  wire logic si1;
  int n_errors, num_checks;
  // released clock lines float high through a pull-up
  assign sck_line[0] = sck_oe[0] ? sck_out[0] : 1'b1;
  assign sck_line[1] = sck_oe[1] ? sck_out[1] : 1'b1;
  assign si1 = so_oe[1] ? so_out[1] : 1'b1;
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    link_clock = 1'b0;
    #3.3;
    forever #15 link_clock = ~link_clock;
  end
  serial3w_ctrl u_serial3w_ctrl (
    .clock(clock), .rst_n(rst_n), .link_clock(link_clock), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .transfer_done_irq_flag(irq), .serial_clock_pin_in(sck_line),
    .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe), .serial_out_pin(so_out),
    .serial_out_pin_oe(so_oe), .serial_in_pin({si1, si0}), .slave_select_pin(ssel)
  );
  serial3w_peer u_serial3w_peer (
    .sck(sck_line[0]), .so(so_out[0]), .si(si0), .load(load), .tx_byte(peer_tx),
    .rx_byte(peer_rx)
  );
  // ----------------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", name, e, g);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge clock);
    #1 reg_write = 1'b0;
  endtask
  task automatic rdc(input string name, input logic [15:0] a, input logic [7:0] e);
    @(posedge clock);
    #1 reg_addr = a;
    reg_read = 1'b1;
    @(posedge clock);
    #1 reg_read = 1'b0;
    chk(name, e, reg_rdata);
  endtask
  task automatic peer_load(input logic [7:0] d);
    peer_tx = d;
    load = 1'b1;
    #1 load = 1'b0;
  endtask
  task automatic wait_done(input int ch);
    int i;
    for (i = 0; i < 500; i++) begin
      @(posedge clock);
      #1;
      if (irq[ch] === 1'b1) break;
    end
    if (i == 500) chk("done pulse", 8'h01, 8'h00);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------------
  initial begin
    #100000;
    n_errors++;
    stop_test;
  end
  initial begin
    {reg_write, reg_read, load, ssel} = 4'h0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    peer_tx = 8'h00;
    n_errors = 0;
    num_checks = 0;
    rst_n = 1'b0;
    repeat (20) @(posedge clock);
    #1 rst_n = 1'b1;
    rdc("mode ch0 reset", MODE_ADDR[0], MODE_RESET);
    rdc("mode ch1 reset", MODE_ADDR[1], MODE_RESET);
    rdc("unmapped", 16'hff82, 8'h00);
    rdc("clksel ch0 reset", CLKSEL_ADDR[0], 8'h00);
    $display("test reset done");
    wr(MODE_ADDR[0], 8'hff);
    rdc("mode ch0 layout", MODE_ADDR[0], 8'hd0);
    chk("ch0 pin owners", 8'h03, {6'h00, sck_oe[0], so_oe[0]});
    wr(MODE_ADDR[1], 8'hff);
    rdc("mode ch1 layout", MODE_ADDR[1], 8'hf0);
    wr(MODE_ADDR[0], 8'h00);
    wr(MODE_ADDR[1], 8'h00);
    @(posedge clock);
    #1 chk("pins released", 8'h00, {4'h0, sck_oe, so_oe});
    $display("test layout done");
    // half period of four link cycles covers the two-flop delay on data in
    wr(CLKSEL_ADDR[0], 8'h02);
    rdc("clksel ch0", CLKSEL_ADDR[0], 8'h02);
    wr(MODE_ADDR[0], 8'hc0);
    peer_load(8'h3c);
    wr(TXBUF_ADDR[0], 8'ha5);
    rdc("busy set", MODE_ADDR[0], 8'hc1);
    wait_done(0);
    rdc("busy clear", MODE_ADDR[0], 8'hc0);
    chk("peer rx msb", 8'ha5, peer_rx);
    peer_load(8'h96);
    rdc("rx msb", SHIFT_ADDR[0], 8'h3c);
    wait_done(0);
    peer_load(8'h0f);
    rdc("rx by read", SHIFT_ADDR[0], 8'h96);
    wr(MODE_ADDR[0], 8'h00);
    rdc("busy after abort", MODE_ADDR[0], 8'h00);
    rdc("shift after abort", SHIFT_ADDR[0], 8'h00);
    $display("test master msb done");
    wr(MODE_ADDR[0], 8'hd0);
    peer_load(8'h35);
    wr(TXBUF_ADDR[0], 8'h01);
    wait_done(0);
    chk("peer rx lsb", 8'h80, peer_rx);
    rdc("rx lsb", SHIFT_ADDR[0], 8'hac);
    wr(MODE_ADDR[0], 8'h00);
    $display("test lsb first done");
    wr(MODE_ADDR[0], 8'h80);
    rdc("mode rx only", MODE_ADDR[0], 8'h80);
    chk("out pin free", 8'h00, {7'h00, so_oe[0]});
    peer_load(8'hc3);
    rdc("shift cleared", SHIFT_ADDR[0], 8'h00);
    wait_done(0);
    rdc("rx only", SHIFT_ADDR[0], 8'hc3);
    wr(MODE_ADDR[0], 8'h00);
    $display("test receive only done");
    wr(CLKSEL_ADDR[1], 8'h02);
    wr(MODE_ADDR[1], 8'hc0);
    wr(TXBUF_ADDR[1], 8'h5a);
    wait_done(1);
    rdc("ch1 loopback", SHIFT_ADDR[1], 8'h5a);
    wr(MODE_ADDR[1], 8'h00);
    $display("test channel 1 done");
    stop_test;
  end
endmodule

// *** sim/serial3w_ctrl_monitor.sv ***
// Purpose: port-level checks of the two-channel 3-wire serial block
// Assumes: mode writes of both channels and channel 0 clock-select writes are mirrored from the register port
// Notes: pin enables are flops, so they lag a register write by one cycle
`timescale 1ns/1ps
module serial3w_ctrl_monitor (
  // clock, reset and register port
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [serial3w_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [serial3w_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [serial3w_pkg::DATA_W-1:0] reg_rdata,
  // events and pin enables
  input wire logic [1:0] transfer_done_irq_flag,
  input wire logic [1:0] serial_clock_pin_oe,
  input wire logic [1:0] serial_out_pin_oe
);
  import serial3w_pkg::*;
  // ----------------------------------------------------------------------------
  // mirror of the written configuration
  // ----------------------------------------------------------------------------
  logic [1:0][DATA_W-1:0] mode_q;
  logic [2:0] cks0;
  logic en0;
  logic rd_mode0;
  logic mapped;
  assign en0 = mode_q[0][MODE_EN_BIT];
  assign rd_mode0 = reg_read && reg_addr == MODE_ADDR[0];
  assign mapped = reg_addr inside {MODE_ADDR[0], MODE_ADDR[1], CLKSEL_ADDR[0], CLKSEL_ADDR[1],
    TXBUF_ADDR[0], TXBUF_ADDR[1], SHIFT_ADDR[0], SHIFT_ADDR[1]};
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= '0;
      cks0 <= 3'h0;
    end else if (reg_write) begin
      for (int i = 0; i < 2; i++) begin
        if (reg_addr == MODE_ADDR[i]) begin
          mode_q[i] <= reg_wdata & MODE_WMASK[i];
        end
      end
      if (reg_addr == CLKSEL_ADDR[0]) begin
        cks0 <= reg_wdata[2:0];
      end
    end
  end
  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking mon_cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_unmapped_zero: assert property (reg_read && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_mode0_layout: assert property (rd_mode0 |=> reg_rdata[7:1] == mode_q[0][7:1])
    else $error("channel 0 mode readback wrong");
  chk_mode1_layout: assert property (reg_read && reg_addr == MODE_ADDR[1]
    |=> reg_rdata[7:1] == mode_q[1][7:1])
    else $error("channel 1 mode readback wrong");
  chk_busy_stop: assert property (rd_mode0 && !en0 |=> !reg_rdata[MODE_BUSY_BIT])
    else $error("busy seen while disabled");
  chk_stop_pins: assert property (!en0 && !$past(en0)
    |-> !serial_clock_pin_oe[0] && !serial_out_pin_oe[0])
    else $error("pin driven in stop mode");
  chk_out_owner: assert property ($stable(mode_q[0])
    |-> serial_out_pin_oe[0] == (en0 && mode_q[0][MODE_TRMD_BIT]))
    else $error("data out ownership wrong");
  chk_clk_owner: assert property ($stable(mode_q[0]) && $stable(cks0)
    |-> serial_clock_pin_oe[0] == (en0 && cks0 != CKS_EXTERNAL))
    else $error("clock pin ownership wrong");
  chk_done_pulse: assert property (transfer_done_irq_flag[0] |=> !transfer_done_irq_flag[0])
    else $error("done pulse longer than one cycle");
  chk_done_enabled: assert property (transfer_done_irq_flag[0] |-> en0)
    else $error("done while disabled");
  chk_done_idle: assert property (transfer_done_irq_flag[0] ##1 rd_mode0
    |=> !reg_rdata[MODE_BUSY_BIT])
    else $error("busy left set after done");
endmodule
bind serial3w_ctrl serial3w_ctrl_monitor u_serial3w_ctrl_monitor (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .transfer_done_irq_flag(transfer_done_irq_flag), .serial_clock_pin_oe(serial_clock_pin_oe),
  .serial_out_pin_oe(serial_out_pin_oe)
);

// *** sim/serial3w_peer.sv ***
// Purpose: external peripheral on channel 0, slave to the block's serial clock
// Assumes: type 1 timing, clock idles high, msb first on its own side
// Notes: bit index counts rising edges, so an aborted frame needs a reload
`timescale 1ns/1ps
module serial3w_peer (
  // link pins
  input wire logic sck,
  input wire logic so,
  output logic si,
  // bench side
  input wire logic load,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  logic [7:0] sh;
  logic [2:0] cnt;
  initial begin
    si = 1'b1;
    sh = 8'h00;
    cnt = 3'h0;
    rx_byte = 8'h00;
  end
  always @(posedge load) begin
    sh = tx_byte;
    cnt = 3'h0;
    si = tx_byte[7];
  end
  // sample on the trailing edge, eight per frame
  always @(posedge sck) begin
    rx_byte = {rx_byte[6:0], so};
    cnt = cnt + 3'h1;
  end
  // change data on the leading edge, away from the sampling edge
  always @(negedge sck) begin
    si = sh[3'h7 - cnt];
  end
endmodule
